// File: rtl/acl_window_pkg.sv
package acl_window_pkg;

    // ----------------------------------------------------------------
    // Bus geometry and register offsets
    // ----------------------------------------------------------------
    localparam int         ADDR_W               = 12;
    localparam int         DATA_W               = 8;
    localparam logic [11:0] OFF_STAGE_BASE      = 12'h600;
    localparam logic [11:0] OFF_ETHERTYPE_LOW   = 12'h609;
    localparam logic [11:0] OFF_PRIORITY_ACTION = 12'h60a;
    localparam logic [11:0] OFF_REMARK_LOW_MAP  = 12'h60b;
    localparam logic [11:0] OFF_SPARE           = 12'h60c;
    localparam logic [11:0] OFF_FORWARD_MASK    = 12'h60d;
    localparam logic [11:0] OFF_RULESET_HIGH    = 12'h60e;
    localparam logic [11:0] OFF_RULESET_LOW     = 12'h60f;
    localparam logic [11:0] OFF_BYTE_SELECT_HIGH = 12'h610;
    localparam logic [11:0] OFF_BYTE_SELECT_LOW  = 12'h611;
    localparam logic [11:0] OFF_ACCESS_CTRL      = 12'h612;

    // ----------------------------------------------------------------
    // Staging byte numbers held in this window
    // ----------------------------------------------------------------
    localparam int STAGE_FIRST     = 9;
    localparam int STAGE_LAST      = 15;
    localparam int BYTE_ETHERTYPE  = 9;
    localparam int BYTE_PRIORITY   = 10;
    localparam int BYTE_REMARK_MAP = 11;
    localparam int BYTE_FORWARD    = 13;
    localparam int BYTE_RULESET_HI = 14;
    localparam int BYTE_RULESET_LO = 15;
    localparam int MATCH_BYTES     = 9;
    localparam int SEL_W           = 16;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int PM_MSB        = 7;
    localparam int PM_LSB        = 6;
    localparam int PRIO_MSB      = 5;
    localparam int PRIO_LSB      = 3;
    localparam int RPE_BIT       = 2;
    localparam int REMARK_HI_MSB = 1;
    localparam int REMARK_HI_LSB = 0;
    localparam int REMARK_LO_BIT = 7;
    localparam int MAP_MSB       = 6;
    localparam int MAP_LSB       = 5;
    localparam int FWD_MSB       = 6;
    localparam int FWD_LSB       = 0;
    localparam int CTRL_WR_DONE  = 6;
    localparam int CTRL_RD_DONE  = 5;
    localparam int CTRL_DIR      = 4;
    localparam int CTRL_IDX_MSB  = 3;
    localparam int CTRL_IDX_LSB  = 0;

    // ----------------------------------------------------------------
    // Reset values, table size and states
    // ----------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE  = 8'h00;
    localparam logic [7:0] ZERO_BYTE   = 8'h00;
    localparam logic       DONE_RESET  = 1'b1;
    localparam logic       DIR_WRITE   = 1'b1;
    localparam int         ENTRY_COUNT = 16;
    localparam int         INDEX_W     = 4;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } xfer_state_t;

endpackage : acl_window_pkg

// File: rtl/acl_entry_access_window.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
module acl_entry_access_window #(
    parameter int ENTRIES = acl_window_pkg::ENTRY_COUNT
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic [11:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata_q,
    output logic             xfer_start_q,
    output logic             xfer_write_q,
    output logic      [3:0]  xfer_index_q,
    output logic      [8:0]  match_byte_select_q,
    output logic      [1:0]  priority_handling_select,
    output logic      [2:0]  priority_value,
    output logic             remark_enable,
    output logic      [2:0]  remark_priority,
    output logic      [1:0]  map_mode,
    output logic      [6:0]  forward_mask,
    output logic      [15:0] ruleset,
    output logic      [7:0]  ethertype_low
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Byte k is chosen by bit 15-k of the joined select pair
    function automatic logic byte_selected(input logic [15:0] sel, input int k);
        byte_selected = sel[acl_window_pkg::SEL_W - 1 - k];
    endfunction : byte_selected

    // True when the address falls on a staging byte of this window
    function automatic logic is_stage(input logic [11:0] a);
        is_stage = (a >= acl_window_pkg::OFF_ETHERTYPE_LOW) && (a <= acl_window_pkg::OFF_RULESET_LOW);
    endfunction : is_stage

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    acl_window_pkg::xfer_state_t state_q, state_d;
    logic [7:0]  stage_q [acl_window_pkg::STAGE_FIRST:acl_window_pkg::STAGE_LAST];
    logic [7:0]  stage_d [acl_window_pkg::STAGE_FIRST:acl_window_pkg::STAGE_LAST];
    logic [7:0]  entry_q [0:ENTRIES-1][acl_window_pkg::STAGE_FIRST:acl_window_pkg::STAGE_LAST];
    logic [7:0]  row_d   [acl_window_pkg::STAGE_FIRST:acl_window_pkg::STAGE_LAST];
    logic [7:0]  sel_high_q, sel_high_d;
    logic [7:0]  sel_low_q, sel_low_d;
    logic        dir_q, dir_d;
    logic [3:0]  index_q, index_d;
    logic        rd_done_q, rd_done_d;
    logic        wr_done_q, wr_done_d;
    logic [7:0]  rdata_d;
    logic        start_d;
    logic [8:0]  match_sel_d;
    logic [15:0] sel_all;
    logic [3:0]  stage_num;
    logic        idle;
    logic        busy;
    logic        trigger;

    assign sel_all   = {sel_high_q, sel_low_q};
    assign stage_num = 4'(reg_addr - acl_window_pkg::OFF_STAGE_BASE);
    assign idle      = (state_q == acl_window_pkg::ST_IDLE);
    assign busy      = (state_q == acl_window_pkg::ST_BUSY);
    // A trigger during a transfer is dropped; the transfer lasts one cycle
    assign trigger   = reg_wr && idle && (reg_addr == acl_window_pkg::OFF_BYTE_SELECT_LOW);

    // ----------------------------------------------------------------
    // Control, select and status next values
    // ----------------------------------------------------------------
    // Writes are refused while busy so the copy sees stable settings
    always_comb begin
        state_d     = state_q;
        sel_high_d  = sel_high_q;
        sel_low_d   = sel_low_q;
        dir_d       = dir_q;
        index_d     = index_q;
        rd_done_d   = rd_done_q;
        wr_done_d   = wr_done_q;
        start_d     = 1'b0;
        match_sel_d = match_byte_select_q;
        if (reg_wr && idle) begin
            unique case (reg_addr)
                acl_window_pkg::OFF_BYTE_SELECT_HIGH: begin
                    sel_high_d = reg_wdata;
                end
                acl_window_pkg::OFF_BYTE_SELECT_LOW: begin
                    sel_low_d = reg_wdata;
                end
                acl_window_pkg::OFF_ACCESS_CTRL: begin
                    dir_d   = reg_wdata[acl_window_pkg::CTRL_DIR];
                    index_d = reg_wdata[acl_window_pkg::CTRL_IDX_MSB:acl_window_pkg::CTRL_IDX_LSB];
                end
                default: begin
                end
            endcase
        end
        if (trigger) begin
            state_d = acl_window_pkg::ST_BUSY;
            start_d = 1'b1;
            if (dir_q == acl_window_pkg::DIR_WRITE) begin
                wr_done_d = 1'b0;
            end else begin
                rd_done_d = 1'b0;
            end
            // Match bytes 0..8 are copied by the neighbouring block
            for (int k = 0; k < acl_window_pkg::MATCH_BYTES; k++) begin
                match_sel_d[k] = byte_selected({sel_high_q, reg_wdata}, k);
            end
        end
        if (busy) begin
            state_d   = acl_window_pkg::ST_IDLE;
            rd_done_d = 1'b1;
            wr_done_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state_q             <= acl_window_pkg::ST_IDLE;
            sel_high_q          <= acl_window_pkg::RESET_BYTE;
            sel_low_q           <= acl_window_pkg::RESET_BYTE;
            dir_q               <= 1'b0;
            index_q             <= '0;
            rd_done_q           <= acl_window_pkg::DONE_RESET;
            wr_done_q           <= acl_window_pkg::DONE_RESET;
            xfer_start_q        <= 1'b0;
            match_byte_select_q <= '0;
        end else begin
            state_q             <= state_d;
            sel_high_q          <= sel_high_d;
            sel_low_q           <= sel_low_d;
            dir_q               <= dir_d;
            index_q             <= index_d;
            rd_done_q           <= rd_done_d;
            wr_done_q           <= wr_done_d;
            xfer_start_q        <= start_d;
            match_byte_select_q <= match_sel_d;
        end
    end

    assign xfer_write_q = dir_q;
    assign xfer_index_q = index_q;

    // ----------------------------------------------------------------
    // Staging bytes and entry table
    // ----------------------------------------------------------------
    // Software writes land when idle; a read transfer merges selected bytes
    always_comb begin
        for (int k = acl_window_pkg::STAGE_FIRST; k <= acl_window_pkg::STAGE_LAST; k++) begin
            stage_d[k] = stage_q[k];
            row_d[k]   = entry_q[index_q][k];
            if (reg_wr && idle && is_stage(reg_addr) && (int'(stage_num) == k)) begin
                stage_d[k] = reg_wdata;
            end
            if (busy && byte_selected(sel_all, k)) begin
                if (dir_q == acl_window_pkg::DIR_WRITE) begin
                    row_d[k] = stage_q[k];
                end else begin
                    stage_d[k] = entry_q[index_q][k];
                end
            end
        end
    end

    // Table is cleared at reset so reads of unused entries are defined
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            for (int k = acl_window_pkg::STAGE_FIRST; k <= acl_window_pkg::STAGE_LAST; k++) begin
                stage_q[k] <= acl_window_pkg::RESET_BYTE;
                for (int e = 0; e < ENTRIES; e++) begin
                    entry_q[e][k] <= acl_window_pkg::RESET_BYTE;
                end
            end
        end else begin
            for (int k = acl_window_pkg::STAGE_FIRST; k <= acl_window_pkg::STAGE_LAST; k++) begin
                stage_q[k]          <= stage_d[k];
                entry_q[index_q][k] <= row_d[k];
            end
        end
    end

    // ----------------------------------------------------------------
    // Decoded action fields
    // ----------------------------------------------------------------
    assign priority_handling_select = stage_q[acl_window_pkg::BYTE_PRIORITY][acl_window_pkg::PM_MSB:acl_window_pkg::PM_LSB];
    assign priority_value           = stage_q[acl_window_pkg::BYTE_PRIORITY][acl_window_pkg::PRIO_MSB:acl_window_pkg::PRIO_LSB];
    assign remark_enable            = stage_q[acl_window_pkg::BYTE_PRIORITY][acl_window_pkg::RPE_BIT];
    assign remark_priority          = {stage_q[acl_window_pkg::BYTE_PRIORITY][acl_window_pkg::REMARK_HI_MSB:acl_window_pkg::REMARK_HI_LSB],
                                       stage_q[acl_window_pkg::BYTE_REMARK_MAP][acl_window_pkg::REMARK_LO_BIT]};
    assign map_mode                 = stage_q[acl_window_pkg::BYTE_REMARK_MAP][acl_window_pkg::MAP_MSB:acl_window_pkg::MAP_LSB];
    assign forward_mask             = stage_q[acl_window_pkg::BYTE_FORWARD][acl_window_pkg::FWD_MSB:acl_window_pkg::FWD_LSB];
    assign ruleset                  = {stage_q[acl_window_pkg::BYTE_RULESET_HI], stage_q[acl_window_pkg::BYTE_RULESET_LO]};
    assign ethertype_low            = stage_q[acl_window_pkg::BYTE_ETHERTYPE];

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Data stands only in the cycle after the strobe; unmapped reads zero
    always_comb begin
        rdata_d = acl_window_pkg::ZERO_BYTE;
        if (reg_rd) begin
            if (is_stage(reg_addr)) begin
                rdata_d = stage_q[int'(stage_num)];
            end else if (reg_addr == acl_window_pkg::OFF_BYTE_SELECT_HIGH) begin
                rdata_d = sel_high_q;
            end else if (reg_addr == acl_window_pkg::OFF_BYTE_SELECT_LOW) begin
                rdata_d = sel_low_q;
            end else if (reg_addr == acl_window_pkg::OFF_ACCESS_CTRL) begin
                rdata_d[acl_window_pkg::CTRL_WR_DONE] = wr_done_q;
                rdata_d[acl_window_pkg::CTRL_RD_DONE] = rd_done_q;
                rdata_d[acl_window_pkg::CTRL_DIR]     = dir_q;
                rdata_d[acl_window_pkg::CTRL_IDX_MSB:acl_window_pkg::CTRL_IDX_LSB] = index_q;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            reg_rdata_q <= acl_window_pkg::ZERO_BYTE;
        end else begin
            reg_rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic [7:0] row_f_now;
    logic [7:0] row_9_now;
    assign row_f_now = entry_q[index_q][acl_window_pkg::BYTE_RULESET_LO];
    assign row_9_now = entry_q[index_q][acl_window_pkg::BYTE_ETHERTYPE];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    property p_trigger_starts;
        trigger |=> busy && xfer_start_q ##1 idle && !xfer_start_q;
    endproperty
    a_trigger_starts: assert property (p_trigger_starts) else $error("trigger did not give one busy cycle");

    property p_read_status;
        trigger && !dir_q |=> !rd_done_q && wr_done_q ##1 rd_done_q;
    endproperty
    a_read_status: assert property (p_read_status) else $error("read status sequence wrong");

    property p_write_status;
        trigger && dir_q |=> !wr_done_q && rd_done_q ##1 wr_done_q;
    endproperty
    a_write_status: assert property (p_write_status) else $error("write status sequence wrong");

    property p_read_copies_f;
        busy && !dir_q && sel_low_q[0] |=> stage_q[acl_window_pkg::BYTE_RULESET_LO] == $past(row_f_now);
    endproperty
    a_read_copies_f: assert property (p_read_copies_f) else $error("selected byte F not loaded");

    property p_read_skips_f;
        busy && !dir_q && !sel_low_q[0] |=> $stable(stage_q[acl_window_pkg::BYTE_RULESET_LO]);
    endproperty
    a_read_skips_f: assert property (p_read_skips_f) else $error("unselected byte F changed");

    property p_write_copies_9;
        busy && dir_q && sel_low_q[6] |=> row_9_now == $past(stage_q[acl_window_pkg::BYTE_ETHERTYPE]);
    endproperty
    a_write_copies_9: assert property (p_write_copies_9) else $error("selected byte 9 not stored");

    property p_high_select_map;
        xfer_start_q |-> match_byte_select_q[0] == sel_high_q[7] && match_byte_select_q[8] == sel_low_q[7];
    endproperty
    a_high_select_map: assert property (p_high_select_map) else $error("match byte select mapping wrong");

    property p_ruleset_readback;
        reg_rd && idle && reg_addr == acl_window_pkg::OFF_RULESET_HIGH |=> reg_rdata_q == ruleset[15:8];
    endproperty
    a_ruleset_readback: assert property (p_ruleset_readback) else $error("ruleset high readback wrong");

    property p_status_idle;
        idle |-> rd_done_q && wr_done_q;
    endproperty
    a_status_idle: assert property (p_status_idle) else $error("status not one while idle");

    c_read_xfer:  cover property (trigger && !dir_q ##2 idle);
    c_write_xfer: cover property (trigger && dir_q ##2 idle);
    c_refused:    cover property (busy && reg_wr && reg_addr == acl_window_pkg::OFF_BYTE_SELECT_LOW);

endmodule : acl_entry_access_window

// File: testbench/test_acl_entry_access_window.sv
`timescale 1ns/100ps
module test_acl_entry_access_window;

    // ----------------------------------------------------------------
    // Clock, stimulus and design outputs
    // ----------------------------------------------------------------
    logic        core_clk;
    logic        resetn;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata_q;
    logic        xfer_start_q;
    logic        xfer_write_q;
    logic [3:0]  xfer_index_q;
    logic [8:0]  match_byte_select_q;
    logic [1:0]  priority_handling_select;
    logic [2:0]  priority_value;
    logic        remark_enable;
    logic [2:0]  remark_priority;
    logic [1:0]  map_mode;
    logic [6:0]  forward_mask;
    logic [15:0] ruleset;
    logic [7:0]  ethertype_low;
    int          n_mismatch;
    int          n_tests;
    int          cycles;
    logic [7:0]  pattern [7];

    acl_entry_access_window u_dut (
        .core_clk                 (core_clk),
        .resetn                   (resetn),
        .reg_addr                 (reg_addr),
        .reg_wdata                (reg_wdata),
        .reg_wr                   (reg_wr),
        .reg_rd                   (reg_rd),
        .reg_rdata_q              (reg_rdata_q),
        .xfer_start_q             (xfer_start_q),
        .xfer_write_q             (xfer_write_q),
        .xfer_index_q             (xfer_index_q),
        .match_byte_select_q      (match_byte_select_q),
        .priority_handling_select (priority_handling_select),
        .priority_value           (priority_value),
        .remark_enable            (remark_enable),
        .remark_priority          (remark_priority),
        .map_mode                 (map_mode),
        .forward_mask             (forward_mask),
        .ruleset                  (ruleset),
        .ethertype_low            (ethertype_low)
    );

    // Free-running 50 ns clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ----------------------------------------------------------------
    // Compare tasks and verdict
    // ----------------------------------------------------------------
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: read got %h expected %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_port(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: port got %h expected %h", $time, got, exp);
        end
    endtask : chk_port

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    // Hang guard, well above the roughly 120 cycles the run needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // ----------------------------------------------------------------
    // Register bus tasks
    // ----------------------------------------------------------------
    // One-cycle write; leaves a gap so the strobe is never assigned twice
    task automatic bus_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : bus_wr

    // Data stands only in the cycle after the strobe, so sample just past that edge
    task automatic bus_rd_chk(input logic [11:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        chk_byte(reg_rdata_q, exp);
    endtask : bus_rd_chk

    // Match byte k follows select bit 15-k
    function automatic logic [8:0] match_of(input logic [7:0] hi, input logic [7:0] lo);
        logic [15:0] s;
        logic [8:0]  m;
        s = {hi, lo};
        for (int k = 0; k < 9; k++) begin
            m[k] = s[15-k];
        end
        return m;
    endfunction : match_of

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset_values;
        for (int i = 0; i < 9; i++) begin
            bus_rd_chk(acl_window_pkg::OFF_ETHERTYPE_LOW + 12'(i), 8'h00);
        end
        bus_rd_chk(acl_window_pkg::OFF_ACCESS_CTRL, 8'h60);
        bus_rd_chk(12'h6ff, 8'h00);
    endtask : test_reset_values

    task automatic test_fields;
        for (int i = 0; i < 7; i++) begin
            bus_wr(acl_window_pkg::OFF_ETHERTYPE_LOW + 12'(i), pattern[i]);
        end
        for (int i = 0; i < 7; i++) begin
            bus_rd_chk(acl_window_pkg::OFF_ETHERTYPE_LOW + 12'(i), pattern[i]);
        end
        chk_port({14'h0000, priority_handling_select}, 16'h0003);
        chk_port({13'h0000, priority_value}, 16'h0002);
        chk_port({15'h0000, remark_enable}, 16'h0001);
        chk_port({13'h0000, remark_priority}, 16'h0005);
        chk_port({14'h0000, map_mode}, 16'h0001);
        chk_port({9'h000, forward_mask}, 16'h0041);
        chk_port(ruleset, 16'h1234);
        chk_port({8'h00, ethertype_low}, 16'h005a);
    endtask : test_fields

    // Write entry 5 with bytes 0, 2, 5, 7, 8, 9 and F selected, then a write in the busy cycle
    task automatic test_write_xfer;
        bus_wr(acl_window_pkg::OFF_ACCESS_CTRL, 8'h15);
        bus_rd_chk(acl_window_pkg::OFF_ACCESS_CTRL, 8'h75);
        bus_wr(acl_window_pkg::OFF_BYTE_SELECT_HIGH, 8'ha5);
        @(posedge core_clk);
        reg_addr  <= acl_window_pkg::OFF_BYTE_SELECT_LOW;
        reg_wdata <= 8'hc1;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_addr  <= acl_window_pkg::OFF_ETHERTYPE_LOW;
        reg_wdata <= 8'hee;
        #1;
        chk_port({15'h0000, xfer_start_q}, 16'h0001);
        chk_port({15'h0000, xfer_write_q}, 16'h0001);
        chk_port({12'h000, xfer_index_q}, 16'h0005);
        chk_port({7'h00, match_byte_select_q}, {7'h00, match_of(8'ha5, 8'hc1)});
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
        chk_port({15'h0000, xfer_start_q}, 16'h0000);
        bus_rd_chk(acl_window_pkg::OFF_ETHERTYPE_LOW, pattern[0]);
        bus_rd_chk(acl_window_pkg::OFF_ACCESS_CTRL, 8'h75);
        bus_rd_chk(acl_window_pkg::OFF_BYTE_SELECT_LOW, 8'hc1);
    endtask : test_write_xfer

    // Clear staging, read entry 5 back with all of bytes 9..F selected
    task automatic test_read_xfer;
        for (int i = 0; i < 7; i++) begin
            bus_wr(acl_window_pkg::OFF_ETHERTYPE_LOW + 12'(i), 8'h00);
        end
        bus_wr(acl_window_pkg::OFF_ACCESS_CTRL, 8'h05);
        bus_wr(acl_window_pkg::OFF_BYTE_SELECT_HIGH, 8'h00);
        bus_wr(acl_window_pkg::OFF_BYTE_SELECT_LOW, 8'h7f);
        #1;
        chk_port({15'h0000, xfer_start_q}, 16'h0001);
        chk_port({15'h0000, xfer_write_q}, 16'h0000);
        chk_port({7'h00, match_byte_select_q}, 16'h0000);
        @(posedge core_clk);
        @(posedge core_clk);
        bus_rd_chk(acl_window_pkg::OFF_ACCESS_CTRL, 8'h65);
        // Byte 9 was written into the entry, bytes A..E were not
        bus_rd_chk(acl_window_pkg::OFF_ETHERTYPE_LOW, pattern[0]);
        for (int i = 1; i < 6; i++) begin
            bus_rd_chk(acl_window_pkg::OFF_ETHERTYPE_LOW + 12'(i), 8'h00);
        end
        bus_rd_chk(acl_window_pkg::OFF_RULESET_LOW, pattern[6]);
        chk_port(ruleset, {8'h00, pattern[6]});
    endtask : test_read_xfer

    // Read entry 5 with only byte 9 selected; byte F must keep its staged value
    task automatic test_partial_read;
        bus_wr(acl_window_pkg::OFF_ETHERTYPE_LOW, 8'h00);
        bus_wr(acl_window_pkg::OFF_RULESET_LOW, 8'hab);
        bus_wr(acl_window_pkg::OFF_BYTE_SELECT_LOW, 8'h40);
        repeat (2) @(posedge core_clk);
        bus_rd_chk(acl_window_pkg::OFF_ETHERTYPE_LOW, pattern[0]);
        bus_rd_chk(acl_window_pkg::OFF_RULESET_LOW, 8'hab);
        chk_port({8'h00, ethertype_low}, {8'h00, pattern[0]});
        chk_port(ruleset, 16'h00ab);
    endtask : test_partial_read

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        n_mismatch = 0;
        n_tests    = 0;
        cycles     = 0;
        resetn     = 1'b0;
        reg_addr   = 12'h000;
        reg_wdata  = 8'h00;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        // Byte 9..F values with every field non-zero and reserved bits set
        pattern    = '{8'h5a, 8'hd6, 8'hbf, 8'hc3, 8'hc1, 8'h12, 8'h34};
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        test_reset_values();
        test_fields();
        test_write_xfer();
        test_read_xfer();
        test_partial_read();
        print_verdict();
    end

endmodule : test_acl_entry_access_window
